/* common/asc_consts.vh */
/*
 constants for the angle sensor digital core: bus address, register word
 addresses, field positions, reset values and timing figures.
 assumes a 50 MHz system clock.
*/
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

`define ASC_CLK_HZ        34'd50000000
`define ASC_SLAVE_ADDR    7'h36

`define ASC_REG_ZSTART_H  8'h01
`define ASC_REG_ZSTART_L  8'h02
`define ASC_REG_ZSTOP_H   8'h03
`define ASC_REG_ZSTOP_L   8'h04
`define ASC_REG_CONF_H    8'h07
`define ASC_REG_CONF_L    8'h08
`define ASC_REG_STATUS    8'h0b
`define ASC_REG_RAW_H     8'h0c
`define ASC_REG_RAW_L     8'h0d
`define ASC_REG_ANG_H     8'h0e
`define ASC_REG_ANG_L     8'h0f
`define ASC_REG_GAIN      8'h1a
`define ASC_REG_MAG_H     8'h1b
`define ASC_REG_MAG_L     8'h1c

`define ASC_CONFH_WDOG    5
`define ASC_CONFL_PWM     4
`define ASC_CONF_H_RST    8'h00
`define ASC_CONF_L_RST    8'h00
`define ASC_GAIN_RST      8'h80

`define ASC_PWM_F0_HZ     34'd115
`define ASC_PWM_F1_HZ     34'd230
`define ASC_PWM_F2_HZ     34'd460
`define ASC_PWM_F3_HZ     34'd920
`define ASC_PWM_PAD       13'd128
`define ASC_PWM_SLOTS     13'd4352

`define ASC_SETTLE0_NS    34'd2200000
`define ASC_SETTLE1_NS    34'd1100000
`define ASC_SETTLE2_NS    34'd550000
`define ASC_SETTLE3_NS    34'd286000
`define ASC_CLK_NS        34'd20
`define ASC_FILT_STEPS    34'd8

`define ASC_WDOG_S        34'd60
`define ASC_WDOG_THR      12'd4

`define ASC_CORDIC_ITER   4'd14

`endif

/* hw/asc_cordic.v */
/*
 iterative vectoring coordinate-rotation engine: turns one x/y field sample
 into a 12-bit angle (full turn = 4096) and a magnitude (gain about 1.647).
 assumes start pulses come no faster than one per 16 clocks; extra ones are dropped.
*/
`timescale 1ns/100ps
`include "asc_consts.vh"

module asc_cordic (
  input  wire               clk,     // system clock
  input  wire               srst,    // synchronous reset
  input  wire               start,   // one-cycle sample strobe
  input  wire signed [11:0] x_in,    // cosine channel
  input  wire signed [11:0] y_in,    // sine channel
  output reg                done,    // one-cycle result strobe
  output reg         [11:0] angle,   // angle result
  output reg         [12:0] mag      // magnitude result
);

  reg signed [14:0] x;
  reg signed [14:0] y;
  reg        [15:0] z;
  reg        [3:0]  iter;
  reg               busy;

  // arctangent of 2^-i in 1/65536 turn units
  function [15:0] atan_step;
    input [3:0] i;
    begin
      case (i)
        4'd0:  atan_step = 16'h2000;
        4'd1:  atan_step = 16'h12e4;
        4'd2:  atan_step = 16'h09fb;
        4'd3:  atan_step = 16'h0511;
        4'd4:  atan_step = 16'h028b;
        4'd5:  atan_step = 16'h0146;
        4'd6:  atan_step = 16'h00a3;
        4'd7:  atan_step = 16'h0051;
        4'd8:  atan_step = 16'h0029;
        4'd9:  atan_step = 16'h0014;
        4'd10: atan_step = 16'h000a;
        4'd11: atan_step = 16'h0005;
        4'd12: atan_step = 16'h0003;
        default: atan_step = 16'h0001;
      endcase
    end
  endfunction

  always @(posedge clk) begin
    done <= 1'b0;
    if (srst) begin
      x     <= 15'h0000;
      y     <= 15'h0000;
      z     <= 16'h0000;
      iter  <= 4'h0;
      busy  <= 1'b0;
      angle <= 12'h000;
      mag   <= 13'h0000;
    end else if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        iter <= 4'h0;
        // fold the left half plane over so the iterations converge
        if (x_in < 0) begin
          x <= -{{3{x_in[11]}}, x_in};
          y <= -{{3{y_in[11]}}, y_in};
          z <= 16'h8000;
        end else begin
          x <= {{3{x_in[11]}}, x_in};
          y <= {{3{y_in[11]}}, y_in};
          z <= 16'h0000;
        end
      end
    end else if (iter == `ASC_CORDIC_ITER) begin
      busy  <= 1'b0;
      done  <= 1'b1;
      angle <= z[15:4];
      mag   <= x[12:0];
    end else begin
      iter <= iter + 4'h1;
      if (y >= 0) begin
        x <= x + (y >>> iter);
        y <= y - (x >>> iter);
        z <= z + atan_step(iter);
      end else begin
        x <= x - (y >>> iter);
        y <= y + (x >>> iter);
        z <= z - atan_step(iter);
      end
    end
  end

endmodule

/* hw/asc_core.v */
/*
 digital core of a contactless rotary position sensor: two-wire bus slave
 with register pointer, angle scaling, settling filter, gain control, pwm and
 dac output selection, and a motion watchdog.
 assumes SCL and SDA_I come straight from pins; field samples and SRST are
 on SYS_CLK. SYS_CLK must be well above 8x the fastest SCL.
*/
`timescale 1ns/100ps
`include "asc_consts.vh"

module asc_core #(
  parameter [33:0] WDOG_CYC   = `ASC_WDOG_S * `ASC_CLK_HZ,
  parameter [33:0] FILT_CYC0  = `ASC_SETTLE0_NS / `ASC_CLK_NS / `ASC_FILT_STEPS,
  parameter [33:0] FILT_CYC1  = `ASC_SETTLE1_NS / `ASC_CLK_NS / `ASC_FILT_STEPS,
  parameter [33:0] FILT_CYC2  = `ASC_SETTLE2_NS / `ASC_CLK_NS / `ASC_FILT_STEPS,
  parameter [33:0] FILT_CYC3  = `ASC_SETTLE3_NS / `ASC_CLK_NS / `ASC_FILT_STEPS,
  parameter [12:0] AGC_TARGET = 13'h0800,
  parameter [12:0] AGC_WIN    = 13'h0100
) (
  input  wire        SYS_CLK,      // 50 MHz system clock
  input  wire        SRST,         // synchronous reset, active high
  input  wire        SCL,          // bus clock pin, input only
  input  wire        SDA_I,        // bus data pin level
  output wire        SDA_O,        // bus data drive value, always low
  output reg         SDA_OE,       // high while pulling SDA low
  input  wire        SAMPLE_VALID, // one-cycle converter strobe
  input  wire [11:0] SAMPLE_X,     // converter cosine channel
  input  wire [11:0] SAMPLE_Y,     // converter sine channel
  output reg  [7:0]  AGC_GAIN,     // front-end gain setting
  output reg         OUT_IS_PWM,   // 1: pwm output, 0: analog output
  output reg         PWM_OUT,      // pulse-width output
  output reg  [11:0] DAC_CODE,     // analog output code
  output reg         WDOG_SLEEP    // no motion for the watchdog time
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_AACK = 7'h04;
  localparam [6:0] ST_RX   = 7'h08;
  localparam [6:0] ST_RACK = 7'h10;
  localparam [6:0] ST_TX   = 7'h20;
  localparam [6:0] ST_TACK = 7'h40;

  // settings held as the non-volatile image
  reg  [11:0] zstart;
  reg  [11:0] zstop;
  reg  [7:0]  conf_h;
  reg  [7:0]  conf_l;
  wire [1:0]  settle_filter_select = conf_h[1:0];
  wire        watchdog_enable_bit  = conf_h[`ASC_CONFH_WDOG];
  wire [1:0]  pulse_freq_select    = conf_l[7:6];

  reg  [11:0] raw_angle;
  reg  [12:0] magnitude;
  reg  [11:0] target;
  reg  [11:0] angle_out;

  function is_valid;
    input [7:0] a;
    begin
      is_valid = (a == `ASC_REG_ZSTART_H) || (a == `ASC_REG_ZSTART_L) ||
                 (a == `ASC_REG_ZSTOP_H) || (a == `ASC_REG_ZSTOP_L) ||
                 (a == `ASC_REG_CONF_H) || (a == `ASC_REG_CONF_L) ||
                 (a == `ASC_REG_STATUS) || (a == `ASC_REG_RAW_H) ||
                 (a == `ASC_REG_RAW_L) || (a == `ASC_REG_ANG_H) ||
                 (a == `ASC_REG_ANG_L) || (a == `ASC_REG_GAIN) ||
                 (a == `ASC_REG_MAG_H) || (a == `ASC_REG_MAG_L);
    end
  endfunction

  // ---------------- bus pins ----------------
  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= SCL;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= SDA_I;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  assign SDA_O = 1'b0;
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ---------------- slave state machine ----------------
  reg [6:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg       rd_mode;
  reg       word_phase;
  reg [7:0] ptr;
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    if (ptr == `ASC_REG_ZSTART_H) begin
      rd_byte = {4'h0, zstart[11:8]};
    end else if (ptr == `ASC_REG_ZSTART_L) begin
      rd_byte = zstart[7:0];
    end else if (ptr == `ASC_REG_ZSTOP_H) begin
      rd_byte = {4'h0, zstop[11:8]};
    end else if (ptr == `ASC_REG_ZSTOP_L) begin
      rd_byte = zstop[7:0];
    end else if (ptr == `ASC_REG_CONF_H) begin
      rd_byte = conf_h;
    end else if (ptr == `ASC_REG_CONF_L) begin
      rd_byte = conf_l;
    end else if (ptr == `ASC_REG_STATUS) begin
      rd_byte = {7'h00, WDOG_SLEEP};
    end else if (ptr == `ASC_REG_RAW_H) begin
      rd_byte = {4'h0, raw_angle[11:8]};
    end else if (ptr == `ASC_REG_RAW_L) begin
      rd_byte = raw_angle[7:0];
    end else if (ptr == `ASC_REG_ANG_H) begin
      rd_byte = {4'h0, angle_out[11:8]};
    end else if (ptr == `ASC_REG_ANG_L) begin
      rd_byte = angle_out[7:0];
    end else if (ptr == `ASC_REG_GAIN) begin
      rd_byte = AGC_GAIN;
    end else if (ptr == `ASC_REG_MAG_H) begin
      rd_byte = {3'h0, magnitude[12:8]};
    end else if (ptr == `ASC_REG_MAG_L) begin
      rd_byte = magnitude[7:0];
    end
  end

  wire hold_ptr = (ptr == `ASC_REG_RAW_H) || (ptr == `ASC_REG_ANG_H) ||
                  (ptr == `ASC_REG_MAG_H);

  // SCL is never an output, so the master's timing always
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      rd_mode    <= 1'b0;
      word_phase <= 1'b0;
      ptr        <= 8'h00;
      SDA_OE     <= 1'b0;
      zstart     <= 12'h000;
      zstop      <= 12'h000;
      conf_h     <= `ASC_CONF_H_RST;
      conf_l     <= `ASC_CONF_L_RST;
    end else if (bus_stop) begin
      state  <= ST_IDLE;
      SDA_OE <= 1'b0;
    end else if (bus_start) begin
      state   <= ST_ADDR;
      bit_cnt <= 4'h0;
      SDA_OE  <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (state == ST_ADDR) begin
              if (shift[7:1] == `ASC_SLAVE_ADDR) begin
                rd_mode    <= shift[0];
                word_phase <= ~shift[0];
                SDA_OE     <= 1'b1;
                state      <= ST_AACK;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              state <= ST_RACK;
              if (word_phase) begin
                word_phase <= 1'b0;
                ptr        <= shift;
                SDA_OE     <= is_valid(shift);
              end else begin
                SDA_OE <= is_valid(ptr);
                ptr    <= ptr + 8'h01;
                if (ptr == `ASC_REG_ZSTART_H) begin
                  zstart[11:8] <= shift[3:0];
                end else if (ptr == `ASC_REG_ZSTART_L) begin
                  zstart[7:0] <= shift;
                end else if (ptr == `ASC_REG_ZSTOP_H) begin
                  zstop[11:8] <= shift[3:0];
                end else if (ptr == `ASC_REG_ZSTOP_L) begin
                  zstop[7:0] <= shift;
                end else if (ptr == `ASC_REG_CONF_H) begin
                  conf_h <= shift;
                end else if (ptr == `ASC_REG_CONF_L) begin
                  conf_l <= shift;
                end
              end
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rd_mode) begin
              shift  <= rd_byte;
              SDA_OE <= ~rd_byte[7];
              state  <= ST_TX;
            end else begin
              SDA_OE <= 1'b0;
              state  <= ST_RX;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            SDA_OE <= 1'b0;
            state  <= ST_RX;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              SDA_OE <= 1'b0;
              state  <= ST_TACK;
              if (!hold_ptr) begin
                ptr <= ptr + 8'h01;
              end else begin
                ptr <= ptr;
              end
            end else begin
              shift  <= {shift[6:0], 1'b0};
              SDA_OE <= ~shift[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            rd_mode <= ~sda_s2; // master ack keeps the read going
          end else if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rd_mode) begin
              shift  <= rd_byte;
              SDA_OE <= ~rd_byte[7];
              state  <= ST_TX;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          SDA_OE <= 1'b0;
          state  <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------- angle path ----------------
  wire        cd_done;
  wire [11:0] cd_angle;
  wire [12:0] cd_mag;

  asc_cordic u_cordic (
    .clk   (SYS_CLK),
    .srst  (SRST),
    .start (SAMPLE_VALID),
    .x_in  (SAMPLE_X),
    .y_in  (SAMPLE_Y),
    .done  (cd_done),
    .angle (cd_angle),
    .mag   (cd_mag)
  );

  wire [11:0] rel  = cd_angle - zstart;
  wire [11:0] span = zstop - zstart;
  wire [12:0] span_full = (span == 12'h000) ? 13'h1000 : {1'b0, span};
  wire [23:0] quot = {rel, 12'h000} / {11'h000, span_full};
  wire [11:0] scaled = ({1'b0, rel} >= span_full || quot[23:12] != 12'h000) ?
                       12'hfff : quot[11:0];

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      raw_angle <= 12'h000;
      magnitude <= 13'h0000;
      target    <= 12'h000;
      AGC_GAIN  <= `ASC_GAIN_RST;
    end else if (cd_done && !WDOG_SLEEP) begin
      raw_angle <= cd_angle;
      magnitude <= cd_mag;
      target    <= scaled;
      if (cd_mag < AGC_TARGET - AGC_WIN && AGC_GAIN != 8'hff) begin
        AGC_GAIN <= AGC_GAIN + 8'h01;
      end else if (cd_mag > AGC_TARGET + AGC_WIN && AGC_GAIN != 8'h00) begin
        AGC_GAIN <= AGC_GAIN - 8'h01;
      end
    end
  end

  // settling filter: halve the error each tick, eight ticks per settling time
  reg  [33:0] filt_cnt;
  reg  [33:0] filt_len;
  wire [12:0] diff = {1'b0, target} - {1'b0, angle_out};
  always @* begin
    case (settle_filter_select)
      2'b00:   filt_len = FILT_CYC0;
      2'b01:   filt_len = FILT_CYC1;
      2'b10:   filt_len = FILT_CYC2;
      default: filt_len = FILT_CYC3;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      filt_cnt  <= 34'h0;
      angle_out <= 12'h000;
    end else if (filt_cnt + 34'h1 >= filt_len) begin
      filt_cnt <= 34'h0;
      // halving stalls two above the target on the way down, so snap there too
      if (diff == 13'h0000 || diff == 13'h0001 || diff == 13'h1fff || diff == 13'h1ffe) begin
        angle_out <= target;
      end else begin
        angle_out <= angle_out + diff[12:1] + {11'h000, diff[12]};
      end
    end else begin
      filt_cnt <= filt_cnt + 34'h1;
    end
  end

  // ---------------- output stage ----------------
  reg  [33:0] unit_len;
  reg  [33:0] unit_cnt;
  reg  [12:0] slot;
  reg  [11:0] pwm_angle;
  always @* begin
    case (pulse_freq_select)
      2'b00:   unit_len = `ASC_CLK_HZ / (`ASC_PWM_F0_HZ * {21'h0, `ASC_PWM_SLOTS});
      2'b01:   unit_len = `ASC_CLK_HZ / (`ASC_PWM_F1_HZ * {21'h0, `ASC_PWM_SLOTS});
      2'b10:   unit_len = `ASC_CLK_HZ / (`ASC_PWM_F2_HZ * {21'h0, `ASC_PWM_SLOTS});
      default: unit_len = `ASC_CLK_HZ / (`ASC_PWM_F3_HZ * {21'h0, `ASC_PWM_SLOTS});
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      unit_cnt   <= 34'h0;
      slot       <= 13'h0000;
      pwm_angle  <= 12'h000;
      PWM_OUT    <= 1'b0;
      DAC_CODE   <= 12'h000;
      OUT_IS_PWM <= 1'b0;
    end else begin
      OUT_IS_PWM <= conf_l[`ASC_CONFL_PWM];
      DAC_CODE   <= angle_out;
      if (!conf_l[`ASC_CONFL_PWM]) begin
        // parked in analog mode so pwm always opens with a whole period
        unit_cnt  <= 34'h0;
        slot      <= 13'h0000;
        pwm_angle <= angle_out;
      end else if (unit_cnt + 34'h1 >= unit_len) begin
        unit_cnt <= 34'h0;
        if (slot == `ASC_PWM_SLOTS - 13'h1) begin
          slot      <= 13'h0000;
          pwm_angle <= angle_out;
        end else begin
          slot <= slot + 13'h1;
        end
      end else begin
        unit_cnt <= unit_cnt + 34'h1;
      end
      // pads of 128 slots keep both edges present at the range ends
      PWM_OUT <= conf_l[`ASC_CONFL_PWM] &&
                 (slot < `ASC_PWM_PAD + {1'b0, pwm_angle});
    end
  end

  // ---------------- motion watchdog ----------------
  reg  [33:0] wd_cnt;
  reg  [11:0] wd_ref;
  wire [11:0] wd_delta = raw_angle - wd_ref;
  wire        moved = (wd_delta > `ASC_WDOG_THR) && (wd_delta < 12'h000 - `ASC_WDOG_THR);
  wire [11:0] live_delta = cd_angle - wd_ref;
  wire        live_moved = cd_done &&
                           (live_delta > `ASC_WDOG_THR) && (live_delta < 12'h000 - `ASC_WDOG_THR);
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      wd_cnt     <= 34'h0;
      wd_ref     <= 12'h000;
      WDOG_SLEEP <= 1'b0;
    end else if (!watchdog_enable_bit || moved || live_moved) begin
      wd_cnt     <= 34'h0;
      wd_ref     <= live_moved ? cd_angle : raw_angle;
      WDOG_SLEEP <= 1'b0;
    end else if (wd_cnt + 34'h1 >= WDOG_CYC) begin
      WDOG_SLEEP <= 1'b1;
    end else begin
      wd_cnt <= wd_cnt + 34'h1;
    end
  end

endmodule

/* dv/asc_core_props.sv */
/*
 checker for the angle sensor core ports: bus pin discipline, gain steps
 and pulse limits. assumes the core's SYS_CLK and synchronous SRST.
*/
`timescale 1ns/100ps
module asc_core_chk (
  input wire       SYS_CLK,      // system clock
  input wire       SRST,         // synchronous reset
  input wire       SCL,          // bus clock pin
  input wire       SDA_O,        // bus data drive value
  input wire       SDA_OE,       // bus data pull enable
  input wire       SAMPLE_VALID, // converter strobe
  input wire [7:0] AGC_GAIN,     // gain setting
  input wire       OUT_IS_PWM,   // output mode
  input wire       PWM_OUT       // pulse output
);
  reg [4:0]  since;
  reg [15:0] hi;
  reg [15:0] lo;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // cycles since last strobe, length of current high and low phase
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      since <= 5'h1f;
      hi    <= 16'h0000;
      lo    <= 16'hffff;
    end else begin
      since <= SAMPLE_VALID ? 5'h00 : since + {4'h0, since != 5'h1f};
      hi    <= PWM_OUT ? hi + {15'h0, hi != 16'hffff} : 16'h0000;
      lo    <= PWM_OUT ? 16'h0000 : lo + {15'h0, lo != 16'hffff};
    end
  end
  sda_od_a: assert property (SDA_O == 1'b0)
    else $error("sda drive value not low");
  oe_rise_a: assert property ($rose(SDA_OE) |-> !SCL)
    else $error("sda pulled while scl high");
  oe_hold_a: assert property (SCL && $past(SCL) |-> $stable(SDA_OE))
    else $error("sda moved while scl high");
  rst_state_a: assert property ($fell(SRST) |-> AGC_GAIN == 8'h80 && !SDA_OE && !PWM_OUT && !OUT_IS_PWM)
    else $error("wrong state after reset");
  gain_step_a: assert property ($changed(AGC_GAIN) |-> (AGC_GAIN - $past(AGC_GAIN) == 8'h01) ||
    ($past(AGC_GAIN) - AGC_GAIN == 8'h01))
    else $error("gain moved by more than one");
  gain_cause_a: assert property ($changed(AGC_GAIN) |-> since < 5'd20)
    else $error("gain moved without a sample");
  pwm_mode_a: assert property (!OUT_IS_PWM && !$past(OUT_IS_PWM) |-> !PWM_OUT)
    else $error("pulse output active in analog mode");
  pwm_high_a: assert property ($fell(PWM_OUT) && OUT_IS_PWM |-> hi >= 16'd1500)
    else $error("pulse high time too short");
  pwm_low_a: assert property ($rose(PWM_OUT) |-> lo >= 16'd1500)
    else $error("pulse low time too short");
endmodule
bind asc_core asc_core_chk asc_core_chk_i (.SYS_CLK(SYS_CLK), .SRST(SRST), .SCL(SCL), .SDA_O(SDA_O),
  .SDA_OE(SDA_OE), .SAMPLE_VALID(SAMPLE_VALID), .AGC_GAIN(AGC_GAIN), .OUT_IS_PWM(OUT_IS_PWM), .PWM_OUT(PWM_OUT));

/* dv/asc_master.sv */
/*
 two-wire bus master model: drives SCL and pulls the open-drain SDA wire.
 assumes clk is the 50 MHz system clock and SDA has a pull-up.
*/
`timescale 1ns/100ps
module asc_master (
  input  wire clk,    // system clock, paces the bus
  input  wire sda_oe, // device pulls SDA low
  output reg  scl,    // bus clock, high when idle
  output wire sda     // resolved SDA level
);
  reg pull;
  assign sda = ~(pull | sda_oe);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // quarter bit of 5 cycles: 400 ns period
  task q;
    repeat (5) @(posedge clk);
  endtask
  task bit_io(input b, output r);
    begin
      pull <= ~b;
      q;
      scl <= 1'b1;
      q;
      r = sda;
      q;
      scl <= 1'b0;
      q;
    end
  endtask
  task start_c;
    begin
      pull <= 1'b0;
      q;
      scl <= 1'b1;
      q;
      pull <= 1'b1;
      q;
      scl <= 1'b0;
      q;
    end
  endtask
  task stop_c;
    begin
      pull <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      pull <= 1'b0;
      q;
    end
  endtask
  task wbyte(input [7:0] d, output ack);
    reg r;
    begin
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask
  task rbyte(input last, output [7:0] d);
    reg r;
    begin
      for (int i = 0; i < 8; i++) begin
        bit_io(1'b1, r);
        d = {d[6:0], r};
      end
      bit_io(last, r);
    end
  endtask
endmodule

/* dv/asc_core_tb.sv */
/*
 testbench for the angle sensor core: register access, samples, scaling,
 pwm timing and watchdog. assumes the master model and bound checker.
*/
`timescale 1ns/100ps
module asc_core_tb;
  reg         sys_clk = 1'b0;
  reg         srst = 1'b1;
  reg         sv = 1'b0;
  reg  [11:0] sx = 12'h000;
  reg  [11:0] sy = 12'h000;
  wire        scl;
  wire        sda;
  wire        sda_oe;
  wire        is_pwm;
  wire        pwm;
  wire        sleep;
  wire [7:0]  gain;
  wire [11:0] dac;
  reg  [7:0]  rb [0:3];
  int         fail_count = 0;
  int         comparisons = 0;
  always #10 sys_clk = ~sys_clk;
  asc_core #(.WDOG_CYC(34'd2000), .FILT_CYC0(34'd4), .FILT_CYC1(34'd4), .FILT_CYC2(34'd4),
    .FILT_CYC3(34'd4)) asc_core_i (.SYS_CLK(sys_clk), .SRST(srst), .SCL(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE(sda_oe), .SAMPLE_VALID(sv), .SAMPLE_X(sx), .SAMPLE_Y(sy), .AGC_GAIN(gain),
    .OUT_IS_PWM(is_pwm), .PWM_OUT(pwm), .DAC_CODE(dac), .WDOG_SLEEP(sleep));
  asc_master asc_master_i (.clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task chk(input string n, input [15:0] e, input [15:0] g);
    begin
      comparisons++;
      if (g !== e) begin
        fail_count++;
        $display("BAD %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wb(input [7:0] d, input e);
    reg a;
    begin
      asc_master_i.wbyte(d, a);
      chk("ack", {15'h0, e}, {15'h0, a});
    end
  endtask
  task setp(input [7:0] p, input e);
    begin
      asc_master_i.start_c;
      wb(8'h6c, 1'b1);
      wb(p, e);
    end
  endtask
  task rd(input [7:0] p, input e, input int n);
    begin
      setp(p, e);
      asc_master_i.start_c;
      wb(8'h6d, 1'b1);
      for (int i = 0; i < n; i++) asc_master_i.rbyte(i == n - 1, rb[i]);
      asc_master_i.stop_c;
    end
  endtask
  task smp(input [11:0] x, input [11:0] y);
    begin
      sx <= x;
      sy <= y;
      sv <= 1'b1;
      @(posedge sys_clk);
      sv <= 1'b0;
      repeat (40) @(posedge sys_clk);
    end
  endtask
  task cnt(input v, output int n);
    begin
      n = 0;
      while (pwm === v && n < 60000) begin
        @(negedge sys_clk);
        n++;
      end
    end
  endtask
  task t_addr;
    begin
      asc_master_i.start_c;
      wb(8'h6e, 1'b0);
      asc_master_i.stop_c;
      $display("address test done");
    end
  endtask
  task t_regs;
    begin
      setp(8'h01, 1'b1);
      wb(8'h05, 1'b1);
      wb(8'h0a, 1'b1);
      asc_master_i.stop_c;
      rd(8'hfe, 1'b0, 4);
      chk("invalid read", 16'h0000, {8'h00, rb[0]});
      chk("wrapped read", 16'h0005, {8'h00, rb[3]});
      rd(8'h02, 1'b1, 1);
      chk("page write", 16'h000a, {8'h00, rb[0]});
      setp(8'h01, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h00, 1'b1);
      asc_master_i.stop_c;
      setp(8'h05, 1'b0);
      wb(8'h11, 1'b0);
      wb(8'h22, 1'b0);
      wb(8'h00, 1'b1);
      asc_master_i.stop_c;
      $display("register test done");
    end
  endtask
  task t_sample;
    reg [7:0]  h;
    reg [11:0] a;
    begin
      smp(12'h000, 12'h400);
      chk("gain", 16'h0081, {8'h00, gain});
      rd(8'h0c, 1'b1, 3);
      chk("raw hold", {8'h00, rb[0]}, {8'h00, rb[2]});
      chk("raw hold second", {8'h00, rb[0]}, {8'h00, rb[1]});
      h = rb[0];
      rd(8'h0d, 1'b1, 1);
      a = {h[3:0], rb[0]};
      chk("raw angle", 16'h0001, {15'h0, a > 12'd1021 && a < 12'd1027});
      chk("dac", 16'h0001, {15'h0, dac > 12'd1019 && dac < 12'd1029});
      setp(8'h03, 1'b1);
      wb(8'h08, 1'b1);
      wb(8'h00, 1'b1);
      asc_master_i.stop_c;
      smp(12'h000, 12'h400);
      repeat (400) @(posedge sys_clk);
      chk("span dac", 16'h0001, {15'h0, dac > 12'd2039 && dac < 12'd2057});
      $display("sample test done");
    end
  endtask
  task t_pwm;
    int h;
    int l;
    int p;
    begin
      setp(8'h08, 1'b1);
      wb(8'hd0, 1'b1);
      asc_master_i.stop_c;
      @(negedge sys_clk);
      chk("pwm mode", 16'h0001, {15'h0, is_pwm});
      cnt(1'b1, h);
      cnt(1'b0, l);
      cnt(1'b1, h);
      p = h + l;
      chk("pwm period", 16'h0001, {15'h0, p > 50000000 / 920 * 95 / 100 && p < 50000000 / 920 * 105 / 100});
      chk("pwm high", 16'h0001, {15'h0, h * 4352 > p * 2154 && h * 4352 < p * 2198});
      $display("pwm test done");
    end
  endtask
  task t_wdog;
    begin
      setp(8'h07, 1'b1);
      wb(8'h20, 1'b1);
      asc_master_i.stop_c;
      smp(12'h400, 12'h000);
      repeat (900) @(posedge sys_clk);
      chk("awake", 16'h0000, {15'h0, sleep});
      repeat (1200) @(posedge sys_clk);
      chk("asleep", 16'h0001, {15'h0, sleep});
      $display("watchdog test done");
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d mismatched %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    t_addr;
    t_regs;
    t_sample;
    t_pwm;
    t_wdog;
    print_verdict;
  end
  initial begin
    repeat (120000) @(posedge sys_clk);
    fail_count++;
    $display("BAD run expected finish seen hang");
    print_verdict;
  end
endmodule
